// ===== design/atm2_timer.v
// 8-bit asynchronous-capable timer with AXI4-Lite register access
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "atm2_defines.vh"
module atm2_timer #(
  parameter SYNC_STAGES = `ATM2_SYNC_STAGES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer_osc_pin_one,
  input  wire [2:0]  irq_vector_ack,
  output reg         ext_clk_buf_en,
  output reg         crystal_osc_en,
  output reg         wave_out_a,
  output reg         wave_out_b,
  output reg         irq
);
  reg [7:0] ctrl_a_q, ctrl_b_q, count_q, cmp_a_q, cmp_b_q;
  reg [7:0] tmp_ctrl_a_q, tmp_ctrl_b_q, tmp_cmp_a_q, tmp_cmp_b_q;
  reg [7:0] tmp_count_q;
  reg [4:0] busy_q;
  reg [4:0] pend_tgl_q, ack_tgl_q;
  reg       ext_clk_q, async_sel_q, tsm_q, psr_q, gie_q;
  reg [2:0] mask_q, flags_q;
  reg [9:0] presc_q;
  reg       osc_s1_q, osc_s2_q, osc_s3_q;
  reg       block_cmp_q, dir_down_q;
  reg       aw_hold_q, w_hold_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire      wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire      wr_lane = w_strb_q[0];
  wire [7:0] wb = w_data_q[7:0];

  function tap_hit;
    input [2:0] sel;
    input [9:0] p;
    begin
      case (sel)
        3'h1: tap_hit = 1'b1;
        3'h2: tap_hit = &p[2:0];
        3'h3: tap_hit = &p[4:0];
        3'h4: tap_hit = &p[5:0];
        3'h5: tap_hit = &p[6:0];
        3'h6: tap_hit = &p[7:0];
        3'h7: tap_hit = &p[9:0];
        default: tap_hit = 1'b0;
      endcase
    end
  endfunction

  function is_wr;
    input [7:0] off;
    begin
      is_wr = wr_fire & wr_lane & (aw_addr_q == off);
    end
  endfunction

  // Async source: oscillator pin is sampled; edge taken after full sync
  // so the first stage feeds only the second.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= timer_osc_pin_one;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end
  wire src_tick = async_sel_q ? (osc_s2_q & ~osc_s3_q) : 1'b1;
  wire presc_clr = psr_q & src_tick;
  wire tick = src_tick & tap_hit(ctrl_b_q[2:0], presc_q);
  wire pwm = (ctrl_a_q[1:0] == 2'b01);
  wire ctc = (ctrl_a_q[1:0] == 2'b10);
  wire fast = (ctrl_a_q[1:0] == 2'b11);
  wire [7:0] top = (ctrl_b_q[`ATM2_BIT_WGM2] | ctc) ? cmp_a_q : 8'hFF;
  wire match_a = (count_q == cmp_a_q);
  wire match_b = (count_q == cmp_b_q);
  wire cmp_ev_a = tick & match_a & ~block_cmp_q;
  wire cmp_ev_b = tick & match_b & ~block_cmp_q;
  // Fast PWM flags at its own top; normal and CTC only at full count
  wire ovf_ev = tick & (pwm ? (dir_down_q & count_q == 8'h01)
                            : fast ? (count_q == top)
                                   : (count_q == 8'hFF));
  // Transfer of temporary storage happens on a source tick in async mode
  wire [4:0] xfer = pend_tgl_q ^ ack_tgl_q;
  wire       xfer_now = async_sel_q & src_tick;

  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ATM2_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q > `ATM2_OFF_CPU_STAT ||
                         aw_addr_q[1:0] != 2'b00) ?
                        `ATM2_RESP_SLVERR : `ATM2_RESP_OKAY;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Registers, counter, flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_a_q <= `ATM2_RESET_BYTE;
      ctrl_b_q <= `ATM2_RESET_BYTE;
      count_q <= `ATM2_RESET_BYTE;
      cmp_a_q <= `ATM2_RESET_BYTE;
      cmp_b_q <= `ATM2_RESET_BYTE;
      tmp_ctrl_a_q <= `ATM2_RESET_BYTE;
      tmp_ctrl_b_q <= `ATM2_RESET_BYTE;
      tmp_cmp_a_q <= `ATM2_RESET_BYTE;
      tmp_cmp_b_q <= `ATM2_RESET_BYTE;
      tmp_count_q <= `ATM2_RESET_BYTE;
      busy_q <= 5'h00;
      pend_tgl_q <= 5'h00;
      ack_tgl_q <= 5'h00;
      ext_clk_q <= 1'b0;
      async_sel_q <= 1'b0;
      tsm_q <= 1'b0;
      psr_q <= 1'b0;
      gie_q <= 1'b0;
      mask_q <= 3'h0;
      flags_q <= 3'h0;
      presc_q <= 10'h000;
      block_cmp_q <= 1'b0;
      dir_down_q <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      irq <= 1'b0;
      ext_clk_buf_en <= 1'b0;
      crystal_osc_en <= 1'b0;
    end
    else
    begin
      // Prescaler; reset request waits for a source tick when async
      if (presc_clr | (psr_q & ~async_sel_q))
        presc_q <= 10'h000;
      else if (src_tick)
        presc_q <= presc_q + 10'h001;
      if (psr_q & ~tsm_q & (~async_sel_q | src_tick))
        psr_q <= 1'b0;
      // Counter advance
      if (tick)
      begin
        block_cmp_q <= 1'b0;
        if (pwm)
        begin
          if (!dir_down_q && count_q == top)
          begin
            dir_down_q <= 1'b1;
            count_q <= count_q - 8'h01;
          end
          else if (dir_down_q && count_q == 8'h01)
          begin
            dir_down_q <= 1'b0;
            count_q <= 8'h00;
          end
          else
            count_q <= dir_down_q ? count_q - 8'h01 : count_q + 8'h01;
        end
        else if (count_q == top)
          count_q <= 8'h00;
        else
          count_q <= count_q + 8'h01;
      end
      if (cmp_ev_a)
        wave_out_a <= ~wave_out_a;
      if (cmp_ev_b)
        wave_out_b <= ~wave_out_b;
      // Flags: hardware set wins over either clear
      flags_q <= (flags_q & ~irq_vector_ack &
                  ~(is_wr(`ATM2_OFF_IRQ_FLAGS) ? wb[2:0] : 3'h0))
                 | {cmp_ev_b, cmp_ev_a, ovf_ev};
      irq <= gie_q & |(flags_q & mask_q);
      ext_clk_buf_en <= ext_clk_q & async_sel_q;
      crystal_osc_en <= ~ext_clk_q & async_sel_q;
      // Temporary storage transfer into live registers in async mode
      if (xfer_now)
      begin
        if (xfer[0]) ctrl_b_q <= tmp_ctrl_b_q;
        if (xfer[1]) ctrl_a_q <= tmp_ctrl_a_q;
        if (xfer[2]) cmp_b_q <= tmp_cmp_b_q;
        if (xfer[3]) cmp_a_q <= tmp_cmp_a_q;
        if (xfer[4])
        begin
          count_q <= tmp_count_q;
          block_cmp_q <= 1'b1;
        end
        ack_tgl_q <= pend_tgl_q;
        busy_q <= busy_q & ~xfer;
      end
      if (wr_fire & wr_lane)
      begin
        case (aw_addr_q)
          `ATM2_OFF_CTRL_A:
          begin
            tmp_ctrl_a_q <= {wb[7:4], 2'b00, wb[1:0]};
            if (async_sel_q) begin busy_q[1] <= 1'b1;
              pend_tgl_q[1] <= ~pend_tgl_q[1]; end
            else ctrl_a_q <= {wb[7:4], 2'b00, wb[1:0]};
          end
          `ATM2_OFF_CTRL_B:
          begin
            // Force bits are strobes and read back as zero
            tmp_ctrl_b_q <= {4'h0, wb[3:0]};
            if (async_sel_q) begin busy_q[0] <= 1'b1;
              pend_tgl_q[0] <= ~pend_tgl_q[0]; end
            else ctrl_b_q <= {4'h0, wb[3:0]};
            if (wb[7] & ~pwm) wave_out_a <= ~wave_out_a;
            if (wb[6] & ~pwm) wave_out_b <= ~wave_out_b;
          end
          `ATM2_OFF_COUNT:
          begin
            tmp_count_q <= wb;
            if (async_sel_q) begin busy_q[4] <= 1'b1;
              pend_tgl_q[4] <= ~pend_tgl_q[4]; end
            else
            begin
              count_q <= wb;
              block_cmp_q <= 1'b1;
            end
          end
          `ATM2_OFF_CMP_A:
          begin
            tmp_cmp_a_q <= wb;
            if (async_sel_q) begin busy_q[3] <= 1'b1;
              pend_tgl_q[3] <= ~pend_tgl_q[3]; end
            else cmp_a_q <= wb;
          end
          `ATM2_OFF_CMP_B:
          begin
            tmp_cmp_b_q <= wb;
            if (async_sel_q) begin busy_q[2] <= 1'b1;
              pend_tgl_q[2] <= ~pend_tgl_q[2]; end
            else cmp_b_q <= wb;
          end
          `ATM2_OFF_ASYNC:
          begin
            ext_clk_q <= wb[`ATM2_BIT_EXT_CLK];
            async_sel_q <= wb[`ATM2_BIT_ASYNC_SEL];
            // Clock switch drops pending transfers; contents may be stale
            if (wb[`ATM2_BIT_ASYNC_SEL] != async_sel_q)
            begin
              busy_q <= 5'h00;
              ack_tgl_q <= pend_tgl_q;
            end
          end
          `ATM2_OFF_IRQ_MASK: mask_q <= wb[2:0];
          `ATM2_OFF_GEN_CTRL:
          begin
            tsm_q <= wb[`ATM2_BIT_TSM];
            if (wb[`ATM2_BIT_PSR]) psr_q <= 1'b1;
          end
          `ATM2_OFF_CPU_STAT: gie_q <= wb[`ATM2_BIT_GIE];
          default: ;
        endcase
      end
    end
  end

  // AXI4-Lite read channel: one-cycle registered answer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ATM2_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ATM2_RESP_OKAY;
        case (s_axi_araddr)
          `ATM2_OFF_CTRL_A:  s_axi_rdata <= {24'h0, tmp_ctrl_a_q};
          `ATM2_OFF_CTRL_B:  s_axi_rdata <= {24'h0, tmp_ctrl_b_q};
          `ATM2_OFF_COUNT:   s_axi_rdata <= {24'h0, count_q};
          `ATM2_OFF_CMP_A:   s_axi_rdata <= {24'h0, tmp_cmp_a_q};
          `ATM2_OFF_CMP_B:   s_axi_rdata <= {24'h0, tmp_cmp_b_q};
          `ATM2_OFF_ASYNC:   s_axi_rdata <= {25'h0, ext_clk_q,
                                            async_sel_q, busy_q};
          `ATM2_OFF_IRQ_MASK: s_axi_rdata <= {29'h0, mask_q};
          `ATM2_OFF_IRQ_FLAGS: s_axi_rdata <= {29'h0, flags_q};
          `ATM2_OFF_GEN_CTRL: s_axi_rdata <= {24'h0, tsm_q, 5'h00,
                                             psr_q, 1'b0};
          `ATM2_OFF_CPU_STAT: s_axi_rdata <= {24'h0, gie_q, 7'h00};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ATM2_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // atm2_timer

// ===== include/atm2_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef ATM2_DEFINES_VH
`define ATM2_DEFINES_VH
`define ATM2_OFF_CTRL_A    8'h00
`define ATM2_OFF_CTRL_B    8'h04
`define ATM2_OFF_COUNT     8'h08
`define ATM2_OFF_CMP_A     8'h0C
`define ATM2_OFF_CMP_B     8'h10
`define ATM2_OFF_ASYNC     8'h14
`define ATM2_OFF_IRQ_MASK  8'h18
`define ATM2_OFF_IRQ_FLAGS 8'h1C
`define ATM2_OFF_GEN_CTRL  8'h20
`define ATM2_OFF_CPU_STAT  8'h24
`define ATM2_BIT_EXT_CLK   6
`define ATM2_BIT_ASYNC_SEL 5
`define ATM2_BIT_TSM       7
`define ATM2_BIT_PSR       1
`define ATM2_BIT_GIE       7
`define ATM2_BIT_OVF       0
`define ATM2_BIT_CMPA      1
`define ATM2_BIT_CMPB      2
`define ATM2_BIT_WGM2      3
`define ATM2_RESET_BYTE    8'h00
`define ATM2_SYNC_STAGES   2
`define ATM2_RESP_OKAY     2'b00
`define ATM2_RESP_SLVERR   2'b10
`endif

// ===== testbench/atm2_timer_assertions.sv
// Checker for the timer register bus and clock source pins
`include "atm2_defines.vh"
module atm2_timer_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        ext_clk_buf_en,
  input wire logic        crystal_osc_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_good;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr <= 8'h24
      && s_axi_awaddr[1:0] == 2'b00;
  endsequence
  sequence s_aw_bad;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h24;
  endsequence
  sequence s_b_answer(logic [1:0] code);
    s_axi_bvalid && s_axi_bresp == code;
  endsequence
  chk_write_okay: assert property (s_aw_good |-> ##[1:4]
    s_b_answer(`ATM2_RESP_OKAY)) else $error("write not answered okay");
  chk_write_unmapped: assert property (s_aw_bad |-> ##[1:4]
    s_b_answer(`ATM2_RESP_SLVERR)) else $error("bad write not refused");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > 8'h24 |=> s_axi_rresp == `ATM2_RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("bad read not refused");
  chk_awready_pulse: assert property (
    s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  chk_clock_source: assert property (
    ext_clk_buf_en |-> !crystal_osc_en)
    else $error("crystal runs with external clock");
endmodule // atm2_timer_checker
bind atm2_timer atm2_timer_checker atm2_timer_checker_inst (.aclk,
  .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .ext_clk_buf_en, .crystal_osc_en);

// ===== testbench/atm2_timer_bench.sv
// Self-checking bench for the timer register block
`include "atm2_defines.vh"
module atm2_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        osc = 1'b0;
  logic [2:0]  ack = 3'h0;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         awready, wready, bvalid, arready, rvalid, ebuf, xtal, irq;
  wire         wave_a, wave_b;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [31:0] rd_v;
  int          dv [6] = '{8, 32, 64, 128, 256, 1024};
  atm2_timer atm2_timer_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_osc_pin_one(osc),
    .irq_vector_ack(ack), .ext_clk_buf_en(ebuf), .crystal_osc_en(xtal),
    .wave_out_a(wave_a), .wave_out_b(wave_b), .irq(irq));
  always #10 aclk = ~aclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bready is raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit da = 0, dw = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw))
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      da = da | awready;
      dw = dw | wready;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    check(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    rd_v = rdata;
    check(rresp, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, `ATM2_RESP_OKAY);
    check(rd_v, exp);
  endtask
  task automatic t_regs;
    rdc(`ATM2_OFF_IRQ_MASK, 8'h00);
    rdc(`ATM2_OFF_IRQ_FLAGS, 8'h00);
    wr(`ATM2_OFF_COUNT, 8'hA5, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_COUNT, 8'hA5);
    wr(8'h28, 8'h11, `ATM2_RESP_SLVERR);
    rd(8'h28, `ATM2_RESP_SLVERR);
    check(rd_v, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_overflow;
    wr(`ATM2_OFF_COUNT, 8'hFE, `ATM2_RESP_OKAY);
    wr(`ATM2_OFF_CTRL_B, 8'h01, `ATM2_RESP_OKAY);
    repeat (10) @(posedge aclk);
    wr(`ATM2_OFF_CTRL_B, 8'h00, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_IRQ_FLAGS, 8'h07);
    // One pass through zero toggles each wave output once
    check({wave_a, wave_b}, 2'b11);
    wr(`ATM2_OFF_IRQ_MASK, 8'h01, `ATM2_RESP_OKAY);
    wr(`ATM2_OFF_CPU_STAT, 8'h80, `ATM2_RESP_OKAY);
    check(irq, 1'b1);
    ack <= 3'b001;
    @(posedge aclk);
    ack <= 3'b000;
    rdc(`ATM2_OFF_IRQ_FLAGS, 8'h06);
    check(irq, 1'b0);
    wr(`ATM2_OFF_IRQ_FLAGS, 8'h06, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_IRQ_FLAGS, 8'h00);
    // Force strobe moves the pin but raises no flag
    wr(`ATM2_OFF_CTRL_B, 8'h40, `ATM2_RESP_OKAY);
    check({wave_a, wave_b}, 2'b10);
    rdc(`ATM2_OFF_IRQ_FLAGS, 8'h00);
    $display("test overflow done");
  endtask
  // Write latency adds a few cycles, so the count may be one off
  task automatic t_prescale;
    for (int i = 0; i < 6; i++)
    begin
      wr(`ATM2_OFF_COUNT, 8'h00, `ATM2_RESP_OKAY);
      wr(`ATM2_OFF_GEN_CTRL, 8'h02, `ATM2_RESP_OKAY);
      rdc(`ATM2_OFF_GEN_CTRL, 8'h00);
      wr(`ATM2_OFF_CTRL_B, 8'(i + 2), `ATM2_RESP_OKAY);
      repeat (dv[i] * 5) @(posedge aclk);
      wr(`ATM2_OFF_CTRL_B, 8'h00, `ATM2_RESP_OKAY);
      rd(`ATM2_OFF_COUNT, `ATM2_RESP_OKAY);
      check(rd_v >= 4 && rd_v <= 6, 1'b1);
    end
    wr(`ATM2_OFF_GEN_CTRL, 8'h82, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_GEN_CTRL, 8'h82);
    wr(`ATM2_OFF_GEN_CTRL, 8'h00, `ATM2_RESP_OKAY);
    $display("test prescale done");
  endtask
  // CTC, phase-correct and fast PWM, each with its top at compare A
  task automatic t_modes;
    logic [7:0] cav [3] = '{8'h02, 8'h01, 8'h03};
    logic [7:0] cbv [3] = '{8'h01, 8'h09, 8'h09};
    logic [7:0] flv [3] = '{8'h06, 8'h07, 8'h07};
    for (int m = 0; m < 3; m++)
    begin
      wr(`ATM2_OFF_CTRL_A, cav[m], `ATM2_RESP_OKAY);
      wr(`ATM2_OFF_CMP_A, 8'h03, `ATM2_RESP_OKAY);
      wr(`ATM2_OFF_COUNT, 8'h00, `ATM2_RESP_OKAY);
      wr(`ATM2_OFF_IRQ_FLAGS, 8'h07, `ATM2_RESP_OKAY);
      wr(`ATM2_OFF_CTRL_B, cbv[m], `ATM2_RESP_OKAY);
      repeat (30) @(posedge aclk);
      wr(`ATM2_OFF_CTRL_B, 8'h00, `ATM2_RESP_OKAY);
      rdc(`ATM2_OFF_IRQ_FLAGS, flv[m]);
      check(irq, flv[m][0]);
      rd(`ATM2_OFF_COUNT, `ATM2_RESP_OKAY);
      check(rd_v <= 3, 1'b1);
    end
    wr(`ATM2_OFF_CTRL_A, 8'h00, `ATM2_RESP_OKAY);
    $display("test modes done");
  endtask
  task automatic t_async;
    wr(`ATM2_OFF_COUNT, 8'h11, `ATM2_RESP_OKAY);
    wr(`ATM2_OFF_ASYNC, 8'h40, `ATM2_RESP_OKAY);
    wr(`ATM2_OFF_ASYNC, 8'h60, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_ASYNC, 8'h60);
    check({ebuf, xtal}, 2'b10);
    wr(`ATM2_OFF_CMP_A, 8'h33, `ATM2_RESP_OKAY);
    wr(`ATM2_OFF_COUNT, 8'h44, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_ASYNC, 8'h78);
    rdc(`ATM2_OFF_CMP_A, 8'h33);
    rdc(`ATM2_OFF_COUNT, 8'h11);
    // With the oscillator idle the prescaler reset cannot finish
    wr(`ATM2_OFF_GEN_CTRL, 8'h02, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_GEN_CTRL, 8'h02);
    repeat (4)
    begin
      repeat (5) @(posedge aclk);
      osc <= ~osc;
    end
    rdc(`ATM2_OFF_ASYNC, 8'h60);
    rdc(`ATM2_OFF_COUNT, 8'h44);
    rdc(`ATM2_OFF_GEN_CTRL, 8'h00);
    wr(`ATM2_OFF_ASYNC, 8'h00, `ATM2_RESP_OKAY);
    rdc(`ATM2_OFF_ASYNC, 8'h00);
    check({ebuf, xtal}, 2'b00);
    wr(`ATM2_OFF_ASYNC, 8'h20, `ATM2_RESP_OKAY);
    check({ebuf, xtal}, 2'b01);
    wr(`ATM2_OFF_ASYNC, 8'h00, `ATM2_RESP_OKAY);
    $display("test async done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_overflow();
    t_prescale();
    t_modes();
    t_async();
    tally_and_finish();
  end
endmodule // atm2_timer_bench
